// File: ppl_pkg.sv
package ppl_pkg;
    // ==========================================================
    // Register map (printed offsets, not all multiples of four)
    localparam logic [7:0] PPL_REG_INDEX = 8'h15;
    localparam logic [7:0] PPL_REG_DATA = 8'h17;
    localparam logic [7:0] PPL_REG_MODE = 8'h20;
    localparam logic [7:0] PPL_REG_STATUS = 8'h21;
    // ==========================================================
    // Field layout
    localparam int PPL_COMP_W = 4;
    localparam int PPL_DATA_LSB = 4;
    localparam int PPL_MODE_MONO_BIT = 2;
    localparam logic [7:0] PPL_INDEX_RESET = 8'h00;
    localparam logic [7:0] PPL_INDEX_STEP = 8'h01;
    localparam logic [7:0] PPL_READ_ZERO = 8'h00;
    localparam logic [3:0] PPL_COMP_RESET = 4'h0;
    // ==========================================================
    // Depth encodings of the mode register, bits 1:0
    typedef enum logic [1:0] {
        PPL_BPP1 = 2'h0,
        PPL_BPP2 = 2'h1,
        PPL_BPP4 = 2'h2,
        PPL_BPP8 = 2'h3
    } ppl_bpp_t;
    // Component selector
    typedef enum logic [1:0] {
        PPL_SEL_RED,
        PPL_SEL_GREEN,
        PPL_SEL_BLUE
    } ppl_sel_t;
    // Pixels per byte and shift per pixel
    localparam logic [3:0] PPL_PIX_1 = 4'h8;
    localparam logic [3:0] PPL_PIX_2 = 4'h4;
    localparam logic [3:0] PPL_PIX_4 = 4'h2;
    localparam logic [3:0] PPL_PIX_8 = 4'h1;
    localparam logic [3:0] PPL_ONE_PIX = 4'h1;
    localparam logic [3:0] PPL_SHIFT_1 = 4'h1;
    localparam logic [3:0] PPL_SHIFT_2 = 4'h2;
    localparam logic [3:0] PPL_SHIFT_4 = 4'h4;
    localparam logic [3:0] PPL_SHIFT_8 = 4'h8;
    localparam logic [3:0] PPL_LEFT_NONE = 4'h0;
    localparam logic [3:0] PPL_NIBBLE_ZERO = 4'h0;
    localparam logic [7:0] PPL_INDEX_LAST = 8'hff;
endpackage

// File: ppl_palette_lookup.sv
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
// ==========================================================
// Summary of operation
// - 1 bpp: eight pixels per byte, leftmost from bit 7.
// - 2 bpp: four pixels per byte, leftmost in bits 7:6, msb at 7.
// - 4 bpp: two pixels per byte, upper nibble first.
// - 8 bpp: whole byte is the palette index.
// - 1 bpp value 0 picks entry 0, value 1 entry 1.
// - 2 bpp uses entries 0 to 3 by pixel value.
// - 4 bpp uses first sixteen entries by nibble value.
// - Monochrome drives gray from the green component only.
// - 8 bpp is refused on monochrome panels.
// - Palette has 256 entries of red, green, blue, 4 bits each.
// - Index register at 15h, read and write, selects entry.
// - Data register at 17h carries component in bits 7:4.
// - Writing the index resets the selector to red.
// - Each data access advances red, green, blue.
// - After blue access the index increments, selector back to red.
module ppl_palette_lookup #(
    parameter int ENTRIES = 256
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // Register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // Buffer byte stream
    input wire logic [7:0] buf_byte_in,
    input wire logic buf_valid_in,
    output logic buf_ready_out,
    // Pixel output
    output logic pix_valid_out,
    output logic [ppl_pkg::PPL_COMP_W-1:0] pix_red_out,
    output logic [ppl_pkg::PPL_COMP_W-1:0] pix_green_out,
    output logic [ppl_pkg::PPL_COMP_W-1:0] pix_blue_out
);
    import ppl_pkg::*;

    localparam int CW = PPL_COMP_W;

    // ==========================================================
    // State
    typedef struct packed {
        logic [7:0] index;
        ppl_sel_t sel;
        ppl_bpp_t bpp;
        logic mono;
        logic [7:0] rdata;
        logic [7:0] shreg;
        logic [3:0] left;
        logic pv;
        logic rdy;
        logic [CW-1:0] r;
        logic [CW-1:0] g;
        logic [CW-1:0] b;
    } ppl_state_t;

    ppl_state_t s_q;
    ppl_state_t s_d;

    // Palette kept outside the struct: one array per component
    logic [CW-1:0] pal_r_q [ENTRIES];
    logic [CW-1:0] pal_g_q [ENTRIES];
    logic [CW-1:0] pal_b_q [ENTRIES];

    logic data_wr;
    logic data_rd;
    logic [7:0] pix_idx;
    logic [3:0] shamt;
    logic [3:0] ppb;
    logic take;

    assign data_wr = reg_wr_in && (reg_addr_in == PPL_REG_DATA);
    assign data_rd = reg_rd_in && (reg_addr_in == PPL_REG_DATA);
    assign take = buf_valid_in && s_q.rdy;

    // ==========================================================
    // Depth decode: pixels per byte and shift per pixel
    always_comb begin
        unique case (s_q.bpp)
            PPL_BPP1: begin
                ppb = PPL_PIX_1;
                shamt = PPL_SHIFT_1;
                pix_idx = {7'h00, s_q.shreg[7]};
            end
            PPL_BPP2: begin
                ppb = PPL_PIX_2;
                shamt = PPL_SHIFT_2;
                pix_idx = {6'h00, s_q.shreg[7:6]};
            end
            PPL_BPP4: begin
                ppb = PPL_PIX_4;
                shamt = PPL_SHIFT_4;
                pix_idx = {4'h0, s_q.shreg[7:4]};
            end
            PPL_BPP8: begin
                ppb = PPL_PIX_8;
                shamt = PPL_SHIFT_8;
                pix_idx = s_q.shreg;
            end
        endcase
    end

    // ==========================================================
    // Next state
    always_comb begin
        s_d = s_q;
        s_d.rdata = PPL_READ_ZERO;
        s_d.pv = 1'b0;
        // Register writes
        if (reg_wr_in) begin
            if (reg_addr_in == PPL_REG_INDEX) begin
                s_d.index = reg_wdata_in;
                s_d.sel = PPL_SEL_RED;
            end
            if (reg_addr_in == PPL_REG_MODE) begin
                s_d.mono = reg_wdata_in[PPL_MODE_MONO_BIT];
                // 8 bpp is not selectable on a mono panel; fall back to 4 bpp
                if (reg_wdata_in[PPL_MODE_MONO_BIT] && ppl_bpp_t'(reg_wdata_in[1:0]) == PPL_BPP8) begin
                    s_d.bpp = PPL_BPP4;
                end else begin
                    s_d.bpp = ppl_bpp_t'(reg_wdata_in[1:0]);
                end
            end
        end
        // Register reads, data valid the next cycle only
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                PPL_REG_INDEX: s_d.rdata = s_q.index;
                PPL_REG_DATA: begin
                    unique case (s_q.sel)
                        PPL_SEL_RED: s_d.rdata = {pal_r_q[s_q.index], 4'h0};
                        PPL_SEL_GREEN: s_d.rdata = {pal_g_q[s_q.index], 4'h0};
                        PPL_SEL_BLUE: s_d.rdata = {pal_b_q[s_q.index], 4'h0};
                        default: s_d.rdata = PPL_READ_ZERO;
                    endcase
                end
                PPL_REG_MODE: s_d.rdata = {5'h00, s_q.mono, s_q.bpp};
                PPL_REG_STATUS: s_d.rdata = {3'h0, s_q.pv, 2'h0, s_q.sel};
                default: s_d.rdata = PPL_READ_ZERO;
            endcase
        end
        // One shared selector for reads and writes
        if (data_wr || data_rd) begin
            unique case (s_q.sel)
                PPL_SEL_RED: s_d.sel = PPL_SEL_GREEN;
                PPL_SEL_GREEN: s_d.sel = PPL_SEL_BLUE;
                PPL_SEL_BLUE: begin
                    s_d.sel = PPL_SEL_RED;
                    s_d.index = s_q.index + PPL_INDEX_STEP;
                end
                default: s_d.sel = PPL_SEL_RED;
            endcase
        end
        // Pixel stream: shift out the current byte, load the next
        if (s_q.left != PPL_LEFT_NONE) begin
            s_d.pv = 1'b1;
            s_d.g = pal_g_q[pix_idx];
            if (s_q.mono) begin
                s_d.r = pal_g_q[pix_idx];
                s_d.b = pal_g_q[pix_idx];
            end else begin
                s_d.r = pal_r_q[pix_idx];
                s_d.b = pal_b_q[pix_idx];
            end
            s_d.shreg = s_q.shreg << shamt;
            s_d.left = s_q.left - PPL_ONE_PIX;
        end
        if (take) begin
            s_d.shreg = buf_byte_in;
            s_d.left = ppb;
        end
        // Ready registered from the next count, so the pin comes from a flop
        s_d.rdy = (s_d.left <= PPL_ONE_PIX);
    end

    // ==========================================================
    // State register
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_q <= '{index: PPL_INDEX_RESET, sel: PPL_SEL_RED, bpp: PPL_BPP1, mono: 1'b0,
                     rdata: PPL_READ_ZERO, shreg: 8'h00, left: 4'h0, pv: 1'b0, rdy: 1'b1,
                     r: PPL_COMP_RESET, g: PPL_COMP_RESET, b: PPL_COMP_RESET};
        end else begin
            s_q <= s_d;
        end
    end

    // Palette writes; no reset since software loads it
    always_ff @(posedge mclk_in) begin
        if (data_wr) begin
            unique case (s_q.sel)
                PPL_SEL_RED: pal_r_q[s_q.index] <= reg_wdata_in[7:PPL_DATA_LSB];
                PPL_SEL_GREEN: pal_g_q[s_q.index] <= reg_wdata_in[7:PPL_DATA_LSB];
                PPL_SEL_BLUE: pal_b_q[s_q.index] <= reg_wdata_in[7:PPL_DATA_LSB];
                default: ;
            endcase
        end
    end

    // ==========================================================
    // Outputs, all from flip-flops
    assign reg_rdata_out = s_q.rdata;
    assign buf_ready_out = s_q.rdy; // Registered, no comb path from inputs
    assign pix_valid_out = s_q.pv;
    assign pix_red_out = s_q.r;
    assign pix_green_out = s_q.g;
    assign pix_blue_out = s_q.b;

    // ==========================================================
    // Checks
    a_index_reset_sel: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        reg_wr_in && reg_addr_in == PPL_REG_INDEX |=> s_q.sel == PPL_SEL_RED)
        else $error("selector not red after index write");
    a_sel_advance: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (data_wr || data_rd) && s_q.sel == PPL_SEL_RED |=> s_q.sel == PPL_SEL_GREEN)
        else $error("selector did not advance");
    a_index_bump: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (data_wr || data_rd) && s_q.sel == PPL_SEL_BLUE
        |=> s_q.index == $past(s_q.index) + PPL_INDEX_STEP && s_q.sel == PPL_SEL_RED)
        else $error("index not bumped after blue");
    a_no_mono_8bpp: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        s_q.mono |-> s_q.bpp != PPL_BPP8)
        else $error("8 bpp on mono panel");
    a_mono_gray: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        s_q.mono && pix_valid_out |-> pix_red_out == pix_green_out && pix_blue_out == pix_green_out)
        else $error("mono not gray");
    a_index_read: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        reg_rd_in && reg_addr_in == PPL_REG_INDEX |=> reg_rdata_out == $past(s_q.index))
        else $error("index readback wrong");
    a_data_low_zero: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        $past(data_rd) |-> reg_rdata_out[3:0] == 4'h0)
        else $error("data low nibble not zero");
    a_byte_pixels: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        take && s_q.bpp == PPL_BPP1 && s_q.bpp == $past(s_q.bpp) |=> s_q.left == PPL_PIX_1)
        else $error("1 bpp byte not eight pixels");
    a_one_bpp_idx: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        s_q.bpp == PPL_BPP1 && s_q.left != 4'h0 && !s_q.mono
        |=> pix_valid_out && pix_red_out == pal_r_q[{7'h00, $past(s_q.shreg[7])}])
        else $error("1 bpp index wrong");

    // ==========================================================
    // Named steps of the register sequencer
    // One data access in each selector position; code 3 never occurs
    sequence s_red_access;
        (data_wr || data_rd) && s_q.sel == PPL_SEL_RED;
    endsequence
    sequence s_green_access;
        (data_wr || data_rd) && s_q.sel == PPL_SEL_GREEN;
    endsequence
    sequence s_blue_access;
        (data_wr || data_rd) && s_q.sel == PPL_SEL_BLUE;
    endsequence
    // Index write seen on the bus
    sequence s_index_write;
        reg_wr_in && reg_addr_in == PPL_REG_INDEX;
    endsequence

    // Selector walks red, green, blue; the index holds until blue is done
    a_green_advance: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        s_green_access |=> s_q.sel == PPL_SEL_BLUE)
        else $error("selector stuck on green");
    a_blue_to_red: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        s_blue_access |=> s_q.sel == PPL_SEL_RED)
        else $error("selector not back to red after blue");
    a_hold_red: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        s_red_access |=> $stable(s_q.index))
        else $error("index moved after red access");
    a_hold_green: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        s_green_access |=> $stable(s_q.index))
        else $error("index moved after green access");
    // Last entry must wrap, or a full palette load would run off the end
    a_index_wrap: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (data_wr || data_rd) && s_q.sel == PPL_SEL_BLUE && s_q.index == PPL_INDEX_LAST
        |=> s_q.index == PPL_INDEX_RESET)
        else $error("index did not wrap");
    a_index_write: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        s_index_write |=> s_q.index == $past(reg_wdata_in))
        else $error("index write lost");

    // Read data carry the addressed component in the upper nibble
    a_read_red: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        data_rd && s_q.sel == PPL_SEL_RED |=> reg_rdata_out == {$past(pal_r_q[s_q.index]), PPL_NIBBLE_ZERO})
        else $error("red readback wrong");
    a_read_green: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        data_rd && s_q.sel == PPL_SEL_GREEN |=> reg_rdata_out == {$past(pal_g_q[s_q.index]), PPL_NIBBLE_ZERO})
        else $error("green readback wrong");
    a_read_blue: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        data_rd && s_q.sel == PPL_SEL_BLUE |=> reg_rdata_out == {$past(pal_b_q[s_q.index]), PPL_NIBBLE_ZERO})
        else $error("blue readback wrong");
    // Read data stand for one cycle only, so a late sampler sees zero
    a_rdata_idle: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        !$past(reg_rd_in) |-> reg_rdata_out == PPL_READ_ZERO)
        else $error("read data outside read cycle");

    // Writes land in the component the selector points at
    a_write_red: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        data_wr && s_q.sel == PPL_SEL_RED |=> pal_r_q[$past(s_q.index)] == $past(reg_wdata_in[7:PPL_DATA_LSB]))
        else $error("red write lost");
    a_write_green: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        data_wr && s_q.sel == PPL_SEL_GREEN |=> pal_g_q[$past(s_q.index)] == $past(reg_wdata_in[7:PPL_DATA_LSB]))
        else $error("green write lost");
    a_write_blue: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        data_wr && s_q.sel == PPL_SEL_BLUE |=> pal_b_q[$past(s_q.index)] == $past(reg_wdata_in[7:PPL_DATA_LSB]))
        else $error("blue write lost");
    // Software asking for 8 bpp on mono gets 4 bpp instead
    a_mono_fallback: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        reg_wr_in && reg_addr_in == PPL_REG_MODE && reg_wdata_in[PPL_MODE_MONO_BIT]
        && ppl_bpp_t'(reg_wdata_in[1:0]) == PPL_BPP8 |=> s_q.bpp == PPL_BPP4)
        else $error("mono 8 bpp not refused");

    // ==========================================================
    // Pixel path: index taken from the top bits of the shift register
    // Changing depth mid-byte is undefined, so these assume a settled mode
    a_two_bpp_idx: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        s_q.bpp == PPL_BPP2 && s_q.left != PPL_LEFT_NONE && !s_q.mono
        |=> pix_valid_out && pix_red_out == pal_r_q[{6'h00, $past(s_q.shreg[7:6])}])
        else $error("2 bpp index wrong");
    a_four_bpp_idx: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        s_q.bpp == PPL_BPP4 && s_q.left != PPL_LEFT_NONE && !s_q.mono
        |=> pix_valid_out && pix_blue_out == pal_b_q[{4'h0, $past(s_q.shreg[7:4])}])
        else $error("4 bpp index wrong");
    a_eight_bpp_idx: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        s_q.bpp == PPL_BPP8 && s_q.left != PPL_LEFT_NONE && !s_q.mono
        |=> pix_valid_out && pix_red_out == pal_r_q[$past(s_q.shreg)])
        else $error("8 bpp index wrong");
    a_mono_green: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        s_q.mono && s_q.left != PPL_LEFT_NONE |=> pix_green_out == pal_g_q[$past(pix_idx)])
        else $error("mono gray not from green");
    // A pixel pulse needs a pixel left in the byte
    a_pix_pulse: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        s_q.left == PPL_LEFT_NONE |=> !pix_valid_out)
        else $error("pixel without byte");
    a_take_load: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        take |=> s_q.left == $past(ppb))
        else $error("byte loaded with wrong pixel count");
    // Ready must drop while more than one pixel remains, or bytes are lost
    a_ready_level: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        s_q.left > PPL_ONE_PIX |-> !buf_ready_out)
        else $error("ready while byte still busy");
endmodule // ppl_palette_lookup

// File: ppl_host_model.sv
`timescale 1ns/1ps
// ==========================================================
// Display buffer byte source on the host side
module ppl_host_model (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // Command from bench
    input wire logic send_in,
    input wire logic [7:0] byte_in,
    // Stream side
    input wire logic buf_ready_in,
    output logic [7:0] buf_byte_out,
    output logic buf_valid_out
);
    // Whole bytes only; a taken byte flips so stale data never matches
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            buf_valid_out <= 1'b0;
            buf_byte_out <= 8'h00;
        end else if (send_in) begin
            buf_valid_out <= 1'b1;
            buf_byte_out <= byte_in;
        end else if (buf_valid_out && buf_ready_in) begin
            buf_valid_out <= 1'b0;
            buf_byte_out <= ~buf_byte_out;
        end
    end
endmodule // ppl_host_model

// File: testbench.sv
`timescale 1ns/1ps
module testbench;
    import ppl_pkg::*;
    // ==========================================================
    // Signals
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, sbyte = 8'h00, rdata, bbyte, q;
    logic wr = 1'b0, rd = 1'b0, send = 1'b0, bvalid, bready, pv;
    logic [3:0] pr, pg, pb;
    logic [3:0] mr [256], mg [256], mb [256];
    int err_total = 0;
    int n_checks = 0;
    // Free-running clock
    always #5 clk = ~clk;
    ppl_palette_lookup ppl_palette_lookup_i (.mclk_in(clk), .rst_n_in(rst_n),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_rdata_out(rdata), .buf_byte_in(bbyte), .buf_valid_in(bvalid),
        .buf_ready_out(bready), .pix_valid_out(pv), .pix_red_out(pr),
        .pix_green_out(pg), .pix_blue_out(pb));
    ppl_host_model ppl_host_model_i (.mclk_in(clk), .rst_n_in(rst_n), .send_in(send),
        .byte_in(sbyte), .buf_ready_in(bready), .buf_byte_out(bbyte), .buf_valid_out(bvalid));
    // ==========================================================
    // Tasks
    task automatic end_sim();
        $display("errors %0d checks %0d", err_total, n_checks);
        if (err_total == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Read data only stands in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    // One byte through the pipe, every pixel judged against the model
    task automatic stream(input logic [7:0] mode, input logic [7:0] px, input int bits, input logic mono);
        logic [7:0] ix;
        int c;
        wr_reg(PPL_REG_MODE, mode);
        @(posedge clk);
        sbyte <= px;
        send <= 1'b1;
        @(posedge clk);
        send <= 1'b0;
        for (int k = 0; k < 8 / bits; k++) begin
            c = 0;
            do begin
                @(posedge clk);
                #1 c++;
            end while (pv !== 1'b1 && c < 20);
            if (c >= 20) begin
                err_total++;
                end_sim();
            end
            ix = (px << (k * bits));
            ix = ix >> (8 - bits);
            chk({pr, pg, pb}, mono ? {3{mg[ix]}} : {mr[ix], mg[ix], mb[ix]});
        end
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        wr_reg(PPL_REG_INDEX, 8'h00);
        for (int i = 0; i < 16; i++) begin
            mr[i] = 4'(i);
            mg[i] = ~4'(i);
            mb[i] = 4'(i + 3);
            wr_reg(PPL_REG_DATA, {mr[i], 4'h0});
            wr_reg(PPL_REG_DATA, {mg[i], 4'h0});
            wr_reg(PPL_REG_DATA, {mb[i], 4'h0});
        end
        rd_reg(PPL_REG_INDEX, q);
        chk(q, 8'h10);
        wr_reg(PPL_REG_INDEX, 8'hff);
        {mr[255], mg[255], mb[255]} = 12'ha5c;
        wr_reg(PPL_REG_DATA, 8'ha0);
        wr_reg(PPL_REG_DATA, 8'h50);
        wr_reg(PPL_REG_DATA, 8'hc0);
        rd_reg(PPL_REG_INDEX, q);
        chk(q, 8'h00);
        wr_reg(PPL_REG_INDEX, 8'h01);
        rd_reg(PPL_REG_DATA, q);
        chk(q, {mr[1], 4'h0});
        rd_reg(PPL_REG_DATA, q);
        chk(q, {mg[1], 4'h0});
        rd_reg(PPL_REG_DATA, q);
        chk(q, {mb[1], 4'h0});
        rd_reg(PPL_REG_INDEX, q);
        chk(q, 8'h02);
        // Half-finished entry, then the selector must restart at red
        wr_reg(PPL_REG_INDEX, 8'h03);
        wr_reg(PPL_REG_DATA, 8'hd0);
        mr[3] = 4'hd;
        wr_reg(PPL_REG_INDEX, 8'h03);
        rd_reg(PPL_REG_DATA, q);
        chk(q, 8'hd0);
        rd_reg(8'h30, q);
        chk(q, 8'h00);
        stream(8'h00, 8'h96, 1, 1'b0);
        stream(8'h01, (8'h1f & 8'hf3) | 8'h08, 2, 1'b0);
        stream(8'h02, 8'h5c, 4, 1'b0);
        stream(8'h03, 8'h0a, 8, 1'b0);
        stream(8'h03, 8'hff, 8, 1'b0);
        stream(8'h07, 8'h3e, 4, 1'b1);
        rd_reg(PPL_REG_MODE, q);
        chk(q, 8'h06);
        rd_reg(PPL_REG_STATUS, q);
        chk(q, 8'h01);
        end_sim();
    end
endmodule // testbench
